// >>> rac_cfg.svh
`ifndef RAC_CFG_SVH
`define RAC_CFG_SVH
// Summary of operation
// RQ1 - own address 0..14, fifteen never answers
// RQ2 - address is selector A plus four times B
// RQ3 - selectors at zero give address zero
// RQ4 - outputs hold until a later update changes them
// RQ5 - controller sends sixteen values, nonzero means on
// RQ6 - packed word bits 0..15 drive channels 1..16
// RQ7 - multi-module updates step the address by one
// RQ8 - shared bus, act only on own address
// RQ9 - three controller lines: data, clock, latch
// RQ10 - controller bit period programmable and clamped
// RQ11 - controller doubles bit period when unreliable
// RQ12 - start both high, sample data on rising clock
// RQ13 - eight address bits, then sixteen bits on match
// RQ14 - latch low-high pulse with clock high transfers
// RQ15 - manual on, off, or automatic per channel
// RQ16 - mismatch ignores cycle, rearm when lines low
// RQ17 - latched bits clear at power-up

// register byte offsets
`define RAC_OFF_CTRL 8'h00
`define RAC_OFF_STAT 8'h04
`define RAC_OFF_LATCH 8'h08
`define RAC_OFF_RELAY 8'h0c
`define RAC_OFF_COUNT 8'h10
// control register fields and reset value
`define RAC_CTRL_EN_BIT 0
`define RAC_CTRL_CLR_BIT 1
`define RAC_CTRL_RST 1'b1
// status register field positions
`define RAC_STAT_ADDR_LSB 0
`define RAC_STAT_OK_BIT 4
`define RAC_STAT_EN_BIT 5
`define RAC_STAT_STATE_LSB 8
// link framing
`define RAC_ABITS 5'd8
`define RAC_DBITS 5'd16
`define RAC_ADDR_RESERVED 4'hf
`define RAC_LATCH_RST 16'h0000
// synchroniser bundle layout
`define RAC_SYNC_W 39
`define RAC_SY_DAT 0
`define RAC_SY_CLK 1
`define RAC_SY_LAT 2
`define RAC_SY_SWA 3
`define RAC_SY_SWB 5
`define RAC_SY_MAN 7
`endif

// >>> rac_pkg.sv
package rac_pkg;
  // receive sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_REARM = 6'h01,
    ST_IDLE = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_SKIP = 6'h10,
    ST_LATCH = 6'h20
  } rac_state_t;
  // manual selector codes; code 3 is treated as automatic
  typedef enum logic [1:0] {
    MAN_AUTO = 2'h0,
    MAN_OFF = 2'h1,
    MAN_ON = 2'h2
  } rac_man_t;
endpackage

// >>> rac_sync.sv
`timescale 1ns/1ps
module rac_sync
  import rac_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // asynchronous inputs and their synchronised copies
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // two stages; first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule // rac_sync

// >>> rac_ahb_regs.sv
`timescale 1ns/1ps
`include "rac_cfg.svh"
module rac_ahb_regs
  import rac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // control towards the receiver
  output logic link_en,
  output logic clr_pulse,
  // state shown to software
  input wire logic [31:0] stat_word,
  input wire logic [15:0] latch_bits,
  input wire logic [15:0] relay_bits,
  input wire logic [31:0] cnt_word
);
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic ctrl_en_r;
  logic clr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;

  // address phase decode; only word transfers are used, hsize not checked
  wire take = hsel & hready & htrans[1];
  wire in_map = (haddr[31:8] == 24'h0);
  wire [7:0] off = {haddr[7:2], 2'b00};
  wire wr_ctrl = wr_pend_r & (wr_addr_r == `RAC_OFF_CTRL);

  // read selection; unmapped offsets read zero
  assign rd_mux = !in_map ? 32'h0 :
                  (off == `RAC_OFF_CTRL) ? {31'h0, ctrl_en_r} :
                  (off == `RAC_OFF_STAT) ? stat_word :
                  (off == `RAC_OFF_LATCH) ? {16'h0, latch_bits} :
                  (off == `RAC_OFF_RELAY) ? {16'h0, relay_bits} :
                  (off == `RAC_OFF_COUNT) ? cnt_word : 32'h0;

  // capture the address phase, read data ready for the data phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0;
    end else begin
      wr_pend_r <= take & hwrite & in_map;
      wr_addr_r <= off;
      if (take && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // control register; clear bit is a self-clearing pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_en_r <= `RAC_CTRL_RST;
      clr_r <= 1'b0;
    end else begin
      clr_r <= wr_ctrl & hwdata[`RAC_CTRL_CLR_BIT];
      if (wr_ctrl) begin
        ctrl_en_r <= hwdata[`RAC_CTRL_EN_BIT];
      end
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign link_en = ctrl_en_r;
  assign clr_pulse = clr_r;
endmodule // rac_ahb_regs

// >>> rac_top.sv
`timescale 1ns/1ps
`include "rac_cfg.svh"
module rac_top
  import rac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // three-wire link, all driven by the controller
  input wire logic serial_data_line,
  input wire logic shift_clock_line,
  input wire logic select_latch_line,
  // address selectors, two bits each
  input wire logic [1:0] addr_sel_a,
  input wire logic [1:0] addr_sel_b,
  // manual selectors, two bits per channel
  input wire logic [31:0] manual_sel,
  // relay drivers, bit 0 is channel one
  output logic [15:0] relay_drive
);

  // selector pair to bus address
  function automatic logic [3:0] rac_switch_addr(input logic [1:0] a, input logic [1:0] b);
    rac_switch_addr = {2'h0, a} + {b, 2'h0};
  endfunction

  // channels whose manual selector shows a given code
  function automatic logic [15:0] rac_mask(input logic [31:0] sel, input logic [1:0] code);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[i] = (sel[2*i +: 2] == code);
    end
    rac_mask = m;
  endfunction

  logic [`RAC_SYNC_W-1:0] raw_in;
  logic [`RAC_SYNC_W-1:0] sync_q;
  rac_state_t state_r;
  rac_state_t state_nxt;
  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic lowseen_r;
  logic lowseen_nxt;
  logic latch_evt;
  logic miss_evt;
  logic clk_prev_r;
  logic [15:0] latch_r;
  logic [15:0] relay_drive_r;
  logic [15:0] relay_nxt;
  logic [15:0] upd_cnt_r;
  logic [15:0] miss_cnt_r;
  logic link_en;
  logic clr_pulse;
  logic [31:0] stat_word;

  // every outside level, link and selectors alike, crosses two flops
  assign raw_in = {manual_sel, addr_sel_b, addr_sel_a,
                   select_latch_line, shift_clock_line, serial_data_line}; // [RQ9]
  rac_sync #(
    .W(`RAC_SYNC_W)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(raw_in),
    .q(sync_q)
  );

  // synchronised link view and edge detection
  wire sdat = sync_q[`RAC_SY_DAT];
  wire sclk = sync_q[`RAC_SY_CLK];
  wire sen = sync_q[`RAC_SY_LAT];
  wire [1:0] sw_a = sync_q[`RAC_SY_SWA +: 2];
  wire [1:0] sw_b = sync_q[`RAC_SY_SWB +: 2];
  wire [31:0] man_q = sync_q[`RAC_SY_MAN +: 32];
  wire clk_rise = sclk & ~clk_prev_r; // [RQ12]
  wire lines_low = ~sclk & ~sen;
  wire lines_high = sclk & sen; // [RQ12]

  // own address; synchroniser resets to zero so address zero until sampled
  wire [3:0] own_addr = rac_switch_addr(sw_a, sw_b); // [RQ2] [RQ3]
  wire addr_ok = (own_addr != `RAC_ADDR_RESERVED); // [RQ1]
  // address byte as it stands once its eighth bit is shifted, lsb first
  wire [7:0] addr_byte = {sdat, shift_r[15:9]};
  wire addr_match = addr_ok & (addr_byte == {4'h0, own_addr}); // [RQ1] [RQ8] [RQ13]

  // manual selector decode; unused code 3 falls back to automatic
  wire [15:0] on_mask = rac_mask(man_q, MAN_ON);
  wire [15:0] off_mask = rac_mask(man_q, MAN_OFF);
  wire [15:0] auto_mask = ~(on_mask | off_mask);
  assign relay_nxt = on_mask | (auto_mask & latch_r); // [RQ15]

  // receive sequencer
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    lowseen_nxt = lowseen_r;
    latch_evt = 1'b0;
    miss_evt = 1'b0;
    case (state_r)
      ST_REARM: begin
        if (lines_low) begin // [RQ16]
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // both lines high opens a cycle; a disabled link just watches it go by
        if (lines_high) begin // [RQ12]
          bit_cnt_nxt = 5'd0;
          state_nxt = link_en ? ST_ADDR : ST_SKIP;
        end
      end
      ST_ADDR: begin
        if (!sen) begin
          state_nxt = ST_REARM;
        end else if (clk_rise) begin
          shift_nxt = {sdat, shift_r[15:1]}; // [RQ12]
          bit_cnt_nxt = bit_cnt_r + 5'd1;
          if (bit_cnt_r == `RAC_ABITS - 5'd1) begin // [RQ13]
            bit_cnt_nxt = 5'd0;
            if (addr_match) begin
              state_nxt = ST_DATA;
            end else begin
              state_nxt = ST_SKIP; // [RQ16]
              miss_evt = 1'b1;
            end
          end
        end
      end
      ST_DATA: begin
        // first data bit ends up in bit 0, channel one
        if (!sen) begin
          state_nxt = ST_REARM;
        end else if (clk_rise) begin
          shift_nxt = {sdat, shift_r[15:1]}; // [RQ13]
          bit_cnt_nxt = bit_cnt_r + 5'd1;
          if (bit_cnt_r == `RAC_DBITS - 5'd1) begin
            state_nxt = ST_LATCH;
            lowseen_nxt = 1'b0;
          end
        end
      end
      ST_LATCH: begin
        // clock must stay high across the low-high latch pulse
        if (!sclk) begin
          state_nxt = ST_REARM;
        end else if (!sen) begin
          lowseen_nxt = 1'b1;
        end else if (lowseen_r) begin
          latch_evt = 1'b1; // [RQ14]
          state_nxt = ST_REARM;
        end
      end
      ST_SKIP: begin
        if (lines_low) begin // [RQ16]
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_REARM;
      end
    endcase
  end

  // sequencer registers; start in rearm as the lines may be mid-cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_REARM;
      bit_cnt_r <= 5'd0;
      shift_r <= 16'h0000;
      lowseen_r <= 1'b0;
      clk_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      lowseen_r <= lowseen_nxt;
      clk_prev_r <= sclk;
    end
  end

  // holding register; a bus latch wins over a software clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_r <= `RAC_LATCH_RST; // [RQ17]
    end else if (latch_evt) begin
      latch_r <= shift_r; // [RQ4] [RQ14]
    end else if (clr_pulse) begin
      latch_r <= `RAC_LATCH_RST;
    end
  end

  // relay drivers and event counters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      relay_drive_r <= 16'h0000;
      upd_cnt_r <= 16'h0000;
      miss_cnt_r <= 16'h0000;
    end else begin
      relay_drive_r <= relay_nxt; // [RQ15]
      upd_cnt_r <= upd_cnt_r + {15'h0, latch_evt};
      miss_cnt_r <= miss_cnt_r + {15'h0, miss_evt};
    end
  end

  // status word for software
  assign stat_word = {18'h0, state_r, 2'h0, link_en, addr_ok, own_addr};

  rac_ahb_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .link_en(link_en),
    .clr_pulse(clr_pulse),
    .stat_word(stat_word),
    .latch_bits(latch_r),
    .relay_bits(relay_drive_r),
    .cnt_word({miss_cnt_r, upd_cnt_r})
  );

  assign relay_drive = relay_drive_r;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_reserved_silent: // [RQ1]
    assert property (state_r == ST_ADDR && clk_rise && sen && own_addr == 4'hf
                     && bit_cnt_r == 5'd7 |=> state_r == ST_SKIP)
    else $error("reserved address accepted a cycle");

  a_switch_address: // [RQ2]
    assert property (state_r == ST_ADDR && clk_rise && sen && bit_cnt_r == 5'd7
                     && addr_byte == {4'h0, sw_b, sw_a} && {sw_b, sw_a} != 4'hf
                     |=> state_r == ST_DATA && bit_cnt_r == 5'd0)
    else $error("matching selector address not accepted");

  a_hold_outputs: // [RQ4]
    assert property ($changed(latch_r) |-> $past(latch_evt) || $past(clr_pulse))
    else $error("holding register changed without an update");

  a_other_address: // [RQ8]
    assert property (state_r == ST_SKIP && !clr_pulse |=> $stable(latch_r))
    else $error("foreign cycle altered the outputs");

  a_rise_sample: // [RQ12]
    assert property ($changed(shift_r) |-> $past(clk_rise) && $past(sen))
    else $error("data shifted off a rising clock");

  a_sixteen_bits: // [RQ13]
    assert property (state_r == ST_DATA && sen && clk_rise && bit_cnt_r == 5'd15
                     |=> state_r == ST_LATCH ##1 !latch_evt)
    else $error("sixteenth bit did not reach latch wait");

  a_latch_pulse: // [RQ14]
    assert property ($changed(upd_cnt_r) |-> $past(state_r) == ST_LATCH
                     && $past(sclk) && $past(sen) && $past(lowseen_r))
    else $error("transfer without low-high latch pulse");

  a_manual_force: // [RQ15]
    assert property (1'b1 |=> (relay_drive_r & $past(off_mask)) == 16'h0000
                     && (relay_drive_r & $past(on_mask)) == $past(on_mask))
    else $error("manual selector not obeyed");

  a_mismatch_rearm: // [RQ16]
    assert property (state_r == ST_SKIP && lines_low |=> state_r == ST_IDLE)
    else $error("skip did not rearm on idle lines");

  a_powerup_clear: // [RQ17]
    assert property (upd_cnt_r == 16'h0000 |-> latch_r == 16'h0000)
    else $error("latched bits set before first update");

  c_update: cover property (latch_evt ##1 state_r == ST_REARM);
  c_mismatch: cover property (miss_evt);
  c_abort: cover property (state_r == ST_DATA && !sen);
  c_forced_on: cover property (on_mask != 16'h0000 && latch_r == 16'h0000);
endmodule // rac_top

// >>> rac_link_ctl.sv
`timescale 1ns/1ps
module rac_link_ctl #(
  parameter int HALF_MIN = 200,
  parameter int HALF_MAX = 3200
) (
  // three controller lines
  output logic serial_data_line,
  output logic shift_clock_line,
  output logic select_latch_line
);
  int half_ns = 400;
  // idle with clock and latch low, the clock stands still between frames
  initial begin
    serial_data_line = 1'b0;
    shift_clock_line = 1'b0;
    select_latch_line = 1'b0;
  end
  // requested bit period is clamped to the controller limits
  task automatic set_period(input int bit_ns);
    half_ns = (bit_ns < 2 * HALF_MIN) ? HALF_MIN : (bit_ns > 2 * HALF_MAX) ? HALF_MAX : bit_ns / 2;
  endtask
  // one cycle: address byte then sixteen controls, lsb first
  task automatic send(input logic [7:0] addr, input logic [15:0] ctl);
    logic [23:0] sh;
    sh = {ctl, addr};
    #(half_ns + 13);
    shift_clock_line = 1'b1;
    select_latch_line = 1'b1;
    #(half_ns);
    for (int i = 0; i < 24; i++) begin
      shift_clock_line = 1'b0;
      serial_data_line = sh[i];
      #(half_ns);
      shift_clock_line = 1'b1;
      #(half_ns);
    end
    select_latch_line = 1'b0;
    #(half_ns);
    select_latch_line = 1'b1;
    #(half_ns);
    shift_clock_line = 1'b0;
    select_latch_line = 1'b0;
    // a released line must not look like it kept its value
    serial_data_line = ~serial_data_line;
  endtask
endmodule // rac_link_ctl

// >>> test_addressed_relay_serial_control.sv
`timescale 1ns/1ps
module test_addressed_relay_serial_control;
  import rac_pkg::*;
  // bench side signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, sd, sc, sl;
  logic [31:0] hrdata, rd;
  logic [1:0] sel_a = 2'h0;
  logic [1:0] sel_b = 2'h0;
  logic [31:0] man = 32'h0;
  logic [15:0] relay;
  logic [15:0] lat = 16'h0;
  int fails = 0;
  int n_tests = 0;
  // 10 mhz system clock
  always #50 clk = ~clk;
  rac_link_ctl link_u (.serial_data_line(sd), .shift_clock_line(sc), .select_latch_line(sl));
  rac_top dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .serial_data_line(sd),
    .shift_clock_line(sc), .select_latch_line(sl), .addr_sel_a(sel_a),
    .addr_sel_b(sel_b), .manual_sel(man), .relay_drive(relay));
  // compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        fails++;
        stop_test();
      end
      @(posedge clk);
    end
  endtask
  // single word transfer, entered just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    q = hrdata;
  endtask
  // manual selector outranks the latched bit
  function automatic logic [15:0] exp_relay(input logic [15:0] l, input logic [31:0] m);
    logic [15:0] r;
    for (int c = 0; c < 16; c++) begin
      r[c] = (m[2*c+:2] == 2'h2) ? 1'b1 : (m[2*c+:2] == 2'h1) ? 1'b0 : l[c];
    end
    return r;
  endfunction
  task automatic check_out(input string name);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk({name, " latch"}, rd, {16'h0, lat});
    chk({name, " relay"}, {16'h0, relay}, {16'h0, exp_relay(lat, man)});
    ahb(1'b0, 32'hc, 32'h0, rd);
    chk({name, " relay reg"}, rd, {16'h0, exp_relay(lat, man)});
    chk({name, " resp"}, {31'h0, hresp}, 32'h0);
    $display("test %s done", name);
  endtask
  // control word: one bit per channel, set means on
  task automatic frame(input logic [7:0] a, input logic [15:0] w);
    link_u.send(a, w);
    @(posedge clk);
    tick(6);
  endtask
  // main sequence
  initial begin
    logic [3:0] own;
    logic [15:0] w;
    logic [31:0] cnt;
    void'($urandom(32'h8168));
    tick(20);
    rstn <= 1'b1;
    tick(4);
    check_out("reset");
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk("default address", {27'h0, rd[4:0]}, 32'h10);
    for (int s = 0; s < 16; s++) begin
      sel_a <= s[1:0];
      sel_b <= s[3:2];
      tick(5);
      ahb(1'b0, 32'h4, 32'h0, rd);
      chk("own address", {27'h0, rd[4:0]}, {27'h0, s != 15, s[3:0]});
    end
    frame(8'h0f, 16'hffff);
    check_out("reserved address");
    for (int i = 0; i < 6; i++) begin
      own = 4'($urandom_range(14));
      sel_a <= own[1:0];
      sel_b <= own[3:2];
      tick(5);
      w = 16'($urandom);
      frame({4'h0, own}, w);
      lat = w;
      check_out("update");
      frame({4'h0, own ^ 4'h1}, ~w);
      check_out("other address");
      frame({4'h1, own}, ~w);
      check_out("high address bits");
    end
    sel_a <= 2'h2;
    sel_b <= 2'h1;
    tick(5);
    // three modules from address five, ours is the middle one
    for (int r = 0; r < 3; r++) begin
      w = 16'($urandom);
      link_u.send(8'h05 + 8'(r), w);
      if (r == 1) lat = w;
    end
    frame(8'h0f, 16'h0);
    check_out("multi module");
    // slower bit periods, the second one clamped
    link_u.set_period(1600);
    lat = 16'($urandom);
    frame(8'h06, lat);
    check_out("doubled period");
    link_u.set_period(100000);
    lat = ~lat;
    frame(8'h06, lat);
    check_out("clamped period");
    link_u.set_period(800);
    for (int i = 0; i < 4; i++) begin
      man <= (i == 0) ? 32'haaaaaaaa : (i == 1) ? 32'h55555555 : $urandom;
      tick(5);
      check_out("manual");
    end
    man <= 32'h0;
    ahb(1'b1, 32'h8, 32'hffffffff, rd);
    tick(3);
    check_out("read only write");
    ahb(1'b0, 32'h40, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // link disabled by software: even its own address is skipped
    ahb(1'b1, 32'h0, 32'h0, rd);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk("ctrl disabled", rd, 32'h0);
    ahb(1'b0, 32'h10, 32'h0, cnt);
    frame(8'h06, ~lat);
    check_out("link disabled");
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk("count disabled", rd, cnt);
    // enabled again: one accepted update and one foreign cycle get counted
    ahb(1'b1, 32'h0, 32'h1, rd);
    w = 16'($urandom);
    frame(8'h06, w);
    lat = w;
    frame(8'h07, ~w);
    check_out("enabled again");
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk("count enabled", rd, cnt + 32'h00010001);
    ahb(1'b1, 32'h0, 32'h3, rd);
    lat = 16'h0;
    tick(3);
    check_out("software clear");
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk("ctrl readback", rd, 32'h1);
    stop_test();
  end
endmodule // test_addressed_relay_serial_control
